// ### rtl/dcif_top.sv
// Dual-core interrupt flags, masks and shared deep-sleep clock gate.
// Assumes an APB master on clk_sys_i and source levels synchronous to it.
//
// Behaviour
// - Flag 1 pending, mask 1 enables
// - Bit 14 latches peer core request
// - Bit 13 is DMA channel 5
// - Bit 12 is DMA channel 4
// - Bit 11 serial1 transmit or DMA 3
// - Bit 10 serial1 receive or DMA 2
// - Bit 9 is host doorbell
// - Bit 7 serial2 transmit or DMA 1
// - Bit 6 serial2 receive or DMA 0
// - Bits 5, 4 serial0 transmit, receive
// - Bit 3 is timer
// - Bits 1, 0 external pins b, a
// - Sleep only when both cores request
// - Both asleep stops shared clocks
// - Entry order between cores is free
`timescale 1ns/100ps
module dcif_top #(
    parameter int unsigned ADDR_W = 8
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Subsystem A sources
    input wire logic [5:0] a_dma_done_i,
    input wire logic [2:0] a_serial_tx_event_i,
    input wire logic [2:0] a_serial_rx_event_i,
    input wire logic a_host_doorbell_irq_i,
    input wire logic a_timer_expiry_irq_i,
    input wire logic a_ext_pin_irq_a_i,
    input wire logic a_ext_pin_irq_b_i,
    input wire logic a_peer_request_field_i,
    input wire logic a_deep_sleep_req_i,
    // Subsystem B sources
    input wire logic [5:0] b_dma_done_i,
    input wire logic [2:0] b_serial_tx_event_i,
    input wire logic [2:0] b_serial_rx_event_i,
    input wire logic b_host_doorbell_irq_i,
    input wire logic b_timer_expiry_irq_i,
    input wire logic b_ext_pin_irq_a_i,
    input wire logic b_ext_pin_irq_b_i,
    input wire logic b_peer_request_field_i,
    input wire logic b_deep_sleep_req_i,
    // Core requests
    output logic core_irq_a_o,
    output logic core_irq_b_o,
    // Clock gate
    output logic clk_run_en_o,
    output logic deep_sleep_state_o,
    // Block interrupt
    output logic irq_o
);
    import dcif_pkg::*;

    // ============================================================
    // Elaboration checks
    // Refused at elaboration, the decode needs 5 to 8 address bits
    if (ADDR_W < 5 || ADDR_W > 8) begin : g_bad_addr_w
        $error("ADDR_W must lie between 5 and 8");
    end

    // ============================================================
    // Source composition
    // Builds one subsystem's flag source vector.
    // Select bit 1 routes the DMA channel, 0 the serial event.
    function automatic logic [15:0] compose(
        input logic [5:0] dma,
        input logic [2:0] tx,
        input logic [2:0] rx,
        input logic host,
        input logic timer,
        input logic pin_a,
        input logic pin_b,
        input logic peer,
        input logic [3:0] sel
    );
        logic [15:0] v;
        v = 16'h0000;
        v[BIT_PEER] = peer;
        v[BIT_DMA5] = dma[5];
        v[BIT_DMA4] = dma[4];
        v[BIT_SP1TX_D3] = sel[3] ? dma[3] : tx[1];
        v[BIT_SP1RX_D2] = sel[2] ? dma[2] : rx[1];
        v[BIT_HOST] = host;
        v[BIT_SP2TX_D1] = sel[1] ? dma[1] : tx[2];
        v[BIT_SP2RX_D0] = sel[0] ? dma[0] : rx[2];
        v[BIT_SP0_TX] = tx[0];
        v[BIT_SP0_RX] = rx[0];
        v[BIT_TIMER] = timer;
        v[BIT_EXT_B] = pin_b;
        v[BIT_EXT_A] = pin_a;
        return v;
    endfunction

    // Maps an address to its register offset, low byte only
    function automatic logic [7:0] ofs(input logic [ADDR_W-1:0] a);
        logic [7:0] o;
        o = 8'h00;
        o[ADDR_W-1:0] = a;
        return o;
    endfunction

    // True for a mapped, aligned offset
    function automatic logic hit(input logic [7:0] o);
        return (o[1:0] == 2'h0) && (o <= OFS_EVT_MASK);
    endfunction

    // ============================================================
    // Register state
    logic [7:0] src_sel;           // Shared-bit routing, A low, B high
    logic [EVT_W-1:0] evt_stat;    // Sticky block events
    logic [EVT_W-1:0] evt_mask;    // Block event enables
    logic [15:0] flags_a, mask_a;  // Subsystem A pair
    logic [15:0] flags_b, mask_b;  // Subsystem B pair
    logic [15:0] src_a, src_b;     // Composed sources
    dcif_sleep_t state, next_state; // Sleep gate state

    // ============================================================
    // APB decode
    logic setup;   // Setup phase seen
    logic wr_go;   // Write takes effect this edge
    logic [7:0] wofs; // Write offset
    logic [31:0] rd_mux;

    assign setup = psel_i & ~penable_i;
    assign wr_go = psel_i & penable_i & pready_o & pwrite_i & ~pslverr_o;
    assign wofs = ofs(paddr_i);

    // Read data selection
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (wofs)
            OFS_FLAGS_A: rd_mux[15:0] = flags_a;
            OFS_MASK_A: rd_mux[15:0] = mask_a;
            OFS_FLAGS_B: rd_mux[15:0] = flags_b;
            OFS_MASK_B: rd_mux[15:0] = mask_b;
            OFS_SRC_SEL: rd_mux[7:0] = src_sel;
            OFS_SLEEP: rd_mux[2:0] = {deep_sleep_state_o,
                                      b_deep_sleep_req_i, a_deep_sleep_req_i};
            OFS_EVT_STAT: rd_mux[EVT_W-1:0] = evt_stat;
            OFS_EVT_MASK: rd_mux[EVT_W-1:0] = evt_mask;
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // Answer in the first access cycle, error on unmapped
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o <= 32'h0000_0000;
        end else begin
            pready_o <= setup;
            pslverr_o <= setup & ~hit(wofs);
            if (setup && !pwrite_i && hit(wofs)) begin
                prdata_o <= rd_mux;
            end else begin
                prdata_o <= 32'h0000_0000;
            end
        end
    end

    // Source routing register
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            src_sel <= SEL_RST;
        end else if (wr_go && wofs == OFS_SRC_SEL) begin
            src_sel <= pwdata_i[7:0];
        end
    end

    // ============================================================
    // Flag banks
    // Each core's peer field raises bit 14 on the other core.
    // A held field gives one event only; it must drop first.
    assign src_a = compose(a_dma_done_i, a_serial_tx_event_i,
        a_serial_rx_event_i, a_host_doorbell_irq_i, a_timer_expiry_irq_i,
        a_ext_pin_irq_a_i, a_ext_pin_irq_b_i, b_peer_request_field_i,
        src_sel[3:0]);
    assign src_b = compose(b_dma_done_i, b_serial_tx_event_i,
        b_serial_rx_event_i, b_host_doorbell_irq_i, b_timer_expiry_irq_i,
        b_ext_pin_irq_a_i, b_ext_pin_irq_b_i, a_peer_request_field_i,
        src_sel[7:4]);

    dcif_flag_bank u_bank_a (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .src_i(src_a),
        .clr_we_i(wr_go && wofs == OFS_FLAGS_A),
        .mask_we_i(wr_go && wofs == OFS_MASK_A),
        .wdata_i(pwdata_i[15:0]),
        .flags_o(flags_a),
        .mask_o(mask_a),
        .irq_o(core_irq_a_o)
    );

    dcif_flag_bank u_bank_b (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .src_i(src_b),
        .clr_we_i(wr_go && wofs == OFS_FLAGS_B),
        .mask_we_i(wr_go && wofs == OFS_MASK_B),
        .wdata_i(pwdata_i[15:0]),
        .flags_o(flags_b),
        .mask_o(mask_b),
        .irq_o(core_irq_b_o)
    );

    // ============================================================
    // Deep-sleep gate
    logic both_req; // Both cores in deep sleep
    logic any_req;  // At least one core asleep

    assign both_req = a_deep_sleep_req_i & b_deep_sleep_req_i;
    assign any_req = a_deep_sleep_req_i | b_deep_sleep_req_i;

    // Next state, either core may arrive first
    always_comb begin
        next_state = state;
        case (state)
            ST_RUN: begin
                if (both_req) begin
                    next_state = ST_SLEEP;
                end else if (any_req) begin
                    next_state = ST_ONE;
                end
            end
            ST_ONE: begin
                if (both_req) begin
                    next_state = ST_SLEEP;
                end else if (!any_req) begin
                    next_state = ST_RUN;
                end
            end
            ST_SLEEP: begin
                if (!both_req) begin
                    next_state = any_req ? ST_ONE : ST_RUN;
                end
            end
            default: next_state = ST_RUN;
        endcase
    end

    // State and clock gate outputs
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            state <= ST_RUN;
            deep_sleep_state_o <= 1'b0;
            clk_run_en_o <= 1'b1;
        end else begin
            state <= next_state;
            deep_sleep_state_o <= (next_state == ST_SLEEP);
            clk_run_en_o <= (next_state != ST_SLEEP);
        end
    end

    // ============================================================
    // Block events
    logic [EVT_W-1:0] evt_set;   // Event pulses
    logic [EVT_W-1:0] evt_clr;   // Write-one-to-clear

    always_comb begin
        evt_set = '0;
        evt_set[EVT_SLEEP_IN] = (next_state == ST_SLEEP) && (state != ST_SLEEP);
        evt_set[EVT_SLEEP_OUT] = (next_state != ST_SLEEP) && (state == ST_SLEEP);
    end

    assign evt_clr = (wr_go && wofs == OFS_EVT_STAT) ?
        pwdata_i[EVT_W-1:0] : EVT_RST;

    // Sticky status, the set wins over the clear
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            evt_stat <= EVT_RST;
        end else begin
            evt_stat <= (evt_stat & ~evt_clr) | evt_set;
        end
    end

    // Event mask
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            evt_mask <= EVT_RST;
        end else if (wr_go && wofs == OFS_EVT_MASK) begin
            evt_mask <= pwdata_i[EVT_W-1:0];
        end
    end

    // Level interrupt output
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(evt_stat & evt_mask);
        end
    end

    // ============================================================
    // Assertions
    a_sleep_needs_both: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        deep_sleep_state_o |-> $past(both_req))
        else $error("deep sleep without both cores");
    a_clock_stops: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        both_req |=> (!clk_run_en_o && deep_sleep_state_o))
        else $error("clocks not stopped in deep sleep");
    a_order_a_first: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (a_deep_sleep_req_i && !b_deep_sleep_req_i) ##1 both_req
        |=> deep_sleep_state_o)
        else $error("sleep missed with core A first");
    a_order_b_first: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (b_deep_sleep_req_i && !a_deep_sleep_req_i) ##1 both_req
        |=> deep_sleep_state_o)
        else $error("sleep missed with core B first");
    a_peer_latch_b: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        $rose(a_peer_request_field_i) |=> flags_b[BIT_PEER] ##1 core_irq_b_o
        || !mask_b[BIT_PEER])
        else $error("peer request not latched on B");
    a_dma3_route: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        ($rose(a_dma_done_i[3]) && src_sel[3] && !$past(a_serial_tx_event_i[1]))
        |=> flags_a[BIT_SP1TX_D3])
        else $error("DMA 3 not routed to bit 11");
    a_host_bit: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        $rose(b_host_doorbell_irq_i) |=> flags_b[BIT_HOST])
        else $error("doorbell not on bit 9");
    a_reserved_zero: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        ((flags_a | mask_a | flags_b | mask_b) & ~FLAG_IMPL) == 16'h0000)
        else $error("reserved bit set");
    a_timer_bit: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        $rose(a_timer_expiry_irq_i) |=> flags_a[BIT_TIMER])
        else $error("timer not on bit 3");
    a_unmapped_err: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (setup && !hit(wofs)) |=> (pready_o && pslverr_o))
        else $error("unmapped access not refused");

    c_deep_sleep: cover property (@(posedge clk_sys_i) disable iff (rst_i)
        $rose(deep_sleep_state_o));
    c_core_irq_a: cover property (@(posedge clk_sys_i) disable iff (rst_i)
        $rose(core_irq_a_o));
    c_peer_to_b: cover property (@(posedge clk_sys_i) disable iff (rst_i)
        $rose(a_peer_request_field_i) ##1 flags_b[BIT_PEER]);
    c_block_irq: cover property (@(posedge clk_sys_i) disable iff (rst_i)
        $rose(irq_o));
endmodule

// ### rtl/dcif_pkg.sv
// Shared constants for the dual-core interrupt flag and sleep gate block.
// Assumes one 100 MHz system clock and an APB register bus.
package dcif_pkg;
    // ============================================================
    // Flag register layout
    localparam int unsigned FLAG_W = 16;
    localparam logic [15:0] FLAG_IMPL = 16'h7EFB; // Bits 15, 8, 2 reserved
    localparam logic [15:0] FLAG_RST = 16'h0000;  // Nothing pending
    localparam logic [15:0] MASK_RST = 16'h0000;  // All masked
    localparam int unsigned BIT_EXT_A = 0;
    localparam int unsigned BIT_EXT_B = 1;
    localparam int unsigned BIT_TIMER = 3;
    localparam int unsigned BIT_SP0_RX = 4;
    localparam int unsigned BIT_SP0_TX = 5;
    localparam int unsigned BIT_SP2RX_D0 = 6;
    localparam int unsigned BIT_SP2TX_D1 = 7;
    localparam int unsigned BIT_HOST = 9;
    localparam int unsigned BIT_SP1RX_D2 = 10;
    localparam int unsigned BIT_SP1TX_D3 = 11;
    localparam int unsigned BIT_DMA4 = 12;
    localparam int unsigned BIT_DMA5 = 13;
    localparam int unsigned BIT_PEER = 14;
    // ============================================================
    // APB byte offsets
    localparam logic [7:0] OFS_FLAGS_A = 8'h00;
    localparam logic [7:0] OFS_MASK_A = 8'h04;
    localparam logic [7:0] OFS_FLAGS_B = 8'h08;
    localparam logic [7:0] OFS_MASK_B = 8'h0C;
    localparam logic [7:0] OFS_SRC_SEL = 8'h10;
    localparam logic [7:0] OFS_SLEEP = 8'h14;
    localparam logic [7:0] OFS_EVT_STAT = 8'h18;
    localparam logic [7:0] OFS_EVT_MASK = 8'h1C;
    localparam logic [7:0] SEL_RST = 8'h00;       // Serial events selected
    // ============================================================
    // Block event bits
    localparam int unsigned EVT_W = 2;
    localparam int unsigned EVT_SLEEP_IN = 0;
    localparam int unsigned EVT_SLEEP_OUT = 1;
    localparam logic [1:0] EVT_RST = 2'h0;
    // Deep-sleep gate states
    typedef enum logic [2:0] {
        ST_RUN = 3'b001,
        ST_ONE = 3'b010,
        ST_SLEEP = 3'b100
    } dcif_sleep_t;
endpackage

// ### rtl/dcif_flag_bank.sv
// One subsystem's pending-flag and enable-mask pair.
// Assumes source levels synchronous to clk_sys_i; a rising edge is an event.
`timescale 1ns/100ps
module dcif_flag_bank (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // Source levels
    input wire logic [15:0] src_i,
    // Register writes
    input wire logic clr_we_i,
    input wire logic mask_we_i,
    input wire logic [15:0] wdata_i,
    // State out
    output logic [15:0] flags_o,
    output logic [15:0] mask_o,
    output logic irq_o
);
    import dcif_pkg::*;

    // ============================================================
    // Event detection
    logic [15:0] src_prev; // Last source levels
    logic [15:0] rise;     // New events this cycle
    logic [15:0] next_flags;

    assign rise = src_i & ~src_prev & FLAG_IMPL;

    // Source history
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            src_prev <= 16'h0000;
        end else begin
            src_prev <= src_i;
        end
    end

    // Write-one-to-clear, a new event beats the clear
    always_comb begin
        next_flags = flags_o;
        if (clr_we_i) begin
            next_flags = next_flags & ~wdata_i;
        end
        next_flags = (next_flags | rise) & FLAG_IMPL;
    end

    // Pending flags
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            flags_o <= FLAG_RST;
        end else begin
            flags_o <= next_flags;
        end
    end

    // Enable mask, reserved bits held at zero
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            mask_o <= MASK_RST;
        end else if (mask_we_i) begin
            mask_o <= wdata_i & FLAG_IMPL;
        end
    end

    // Request to the core: pending and enabled
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(flags_o & mask_o);
        end
    end

    a_event_latch: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (rise != 16'h0000) |=> ((flags_o & $past(rise)) == $past(rise)))
        else $error("event not latched as pending");
    a_masked_quiet: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        ((flags_o & mask_o) == 16'h0000) |=> !irq_o)
        else $error("core request without enabled pending flag");
endmodule

// ### dv/dcif_src_model.sv
// Source model: peripherals and peer core of one subsystem.
// Assumes the bench pulses fire_i in the flag bit layout for one cycle.
`timescale 1ns/100ps
module dcif_src_model (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // Bench commands
    input wire logic [15:0] fire_i,
    input wire logic [3:0] use_dma_i,
    // Source levels
    output logic [5:0] dma_done_o,
    output logic [2:0] tx_o,
    output logic [2:0] rx_o,
    output logic host_o,
    output logic timer_o,
    output logic pin_a_o,
    output logic pin_b_o,
    output logic peer_o
);
    logic [15:0] lvl; // Level held two cycles
    logic [15:0] hold; // Previous command
    // ============================================================
    // Stretch each command and drop it again before the next one
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            lvl <= 16'h0000;
            hold <= 16'h0000;
        end else begin
            hold <= fire_i;
            lvl <= fire_i | hold;
        end
    end
    // Shared bits pick the DMA or the serial line
    assign dma_done_o = {lvl[13], lvl[12], lvl[11] & use_dma_i[3], lvl[10] & use_dma_i[2],
                         lvl[7] & use_dma_i[1], lvl[6] & use_dma_i[0]};
    assign tx_o = {lvl[7] & ~use_dma_i[1], lvl[11] & ~use_dma_i[3], lvl[5]};
    assign rx_o = {lvl[6] & ~use_dma_i[0], lvl[10] & ~use_dma_i[2], lvl[4]};
    assign host_o = lvl[9];
    assign timer_o = lvl[3];
    assign pin_a_o = lvl[0];
    assign pin_b_o = lvl[1];
    // Peer field rises once, then falls before any further request
    assign peer_o = lvl[14];
endmodule

// ### dv/tb_top.sv
// Testbench: APB register access, source events and deep-sleep gate.
// Assumes dcif_top with an 8-bit address and one source model per core.
`timescale 1ns/100ps
module tb_top;
    import dcif_pkg::*;
    // ============================================================
    // Signals
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, d;
    logic pready, pslverr, last_err;
    logic [15:0] fire_a = 16'h0, fire_b = 16'h0, m;
    logic [3:0] dma_a = 4'h0, dma_b = 4'h0;
    logic sleep_a = 1'b0, sleep_b = 1'b0;
    logic [5:0] a_dma, b_dma;
    logic [2:0] a_tx, a_rx, b_tx, b_rx;
    logic a_host, a_tmr, a_pa, a_pb, a_peer, b_host, b_tmr, b_pa, b_pb, b_peer;
    logic irq_a, irq_b, run_en, asleep, blk_irq;
    int fail_count = 0, n_compared = 0, tgt;
    int unsigned bits [13] = '{0, 1, 3, 4, 5, 6, 7, 9, 10, 11, 12, 13, 14};
    logic [7:0] ofs [8] = '{OFS_FLAGS_A, OFS_MASK_A, OFS_FLAGS_B, OFS_MASK_B,
                            OFS_SRC_SEL, OFS_SLEEP, OFS_EVT_STAT, OFS_EVT_MASK};
    // Clock, 10 ns
    initial begin
        forever #5 clk_sys_i = ~clk_sys_i;
    end
    dcif_src_model dcif_src_model_a_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .fire_i(fire_a),
        .use_dma_i(dma_a), .dma_done_o(a_dma), .tx_o(a_tx), .rx_o(a_rx), .host_o(a_host),
        .timer_o(a_tmr), .pin_a_o(a_pa), .pin_b_o(a_pb), .peer_o(a_peer));
    dcif_src_model dcif_src_model_b_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .fire_i(fire_b),
        .use_dma_i(dma_b), .dma_done_o(b_dma), .tx_o(b_tx), .rx_o(b_rx), .host_o(b_host),
        .timer_o(b_tmr), .pin_a_o(b_pa), .pin_b_o(b_pb), .peer_o(b_peer));
    dcif_top #(.ADDR_W(8)) dcif_top_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .a_dma_done_i(a_dma), .a_serial_tx_event_i(a_tx), .a_serial_rx_event_i(a_rx),
        .a_host_doorbell_irq_i(a_host), .a_timer_expiry_irq_i(a_tmr), .a_ext_pin_irq_a_i(a_pa),
        .a_ext_pin_irq_b_i(a_pb), .a_peer_request_field_i(a_peer), .a_deep_sleep_req_i(sleep_a),
        .b_dma_done_i(b_dma), .b_serial_tx_event_i(b_tx), .b_serial_rx_event_i(b_rx),
        .b_host_doorbell_irq_i(b_host), .b_timer_expiry_irq_i(b_tmr), .b_ext_pin_irq_a_i(b_pa),
        .b_ext_pin_irq_b_i(b_pb), .b_peer_request_field_i(b_peer), .b_deep_sleep_req_i(sleep_b),
        .core_irq_a_o(irq_a), .core_irq_b_o(irq_b), .clk_run_en_o(run_en),
        .deep_sleep_state_o(asleep), .irq_o(blk_irq));
    // ============================================================
    // Tasks
    // One APB transfer; result taken at the edge where pready is high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk_sys_i);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk_sys_i);
        penable <= 1'b1;
        // Only the watchdog ends a wait for the answer
        do begin
            @(posedge clk_sys_i);
        end while (pready !== 1'b1);
        d = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Pulse one model and let the flag settle
    task automatic fire(input int s, input logic [15:0] fm, input logic [3:0] u);
        @(posedge clk_sys_i);
        if (s == 0) begin
            fire_a <= fm;
            dma_a <= u;
        end else begin
            fire_b <= fm;
            dma_b <= u;
        end
        @(posedge clk_sys_i);
        fire_a <= 16'h0000;
        fire_b <= 16'h0000;
        repeat (5) @(posedge clk_sys_i);
    endtask
    task automatic complete_run();
        $display("Checks %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // ============================================================
    // Watchdog
    initial begin
        repeat (20000) @(posedge clk_sys_i);
        fail_count++;
        complete_run();
    end
    // Main sequence
    initial begin
        repeat (8) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        // Reset values of every register
        foreach (ofs[i]) begin
            apb(1'b0, ofs[i], 32'h0);
            chk(d, 32'h0);
        end
        chk({31'h0, run_en}, 32'h1);
        $display("test reset done");
        // Every flag bit fires from its source under serial routing, peer on the other core
        apb(1'b1, OFS_MASK_A, 32'hFFFF);
        apb(1'b1, OFS_MASK_B, 32'hFFFF);
        apb(1'b0, OFS_MASK_A, 32'h0);
        chk(d, {16'h0, FLAG_IMPL});
        for (int s = 0; s < 2; s++) begin
            foreach (bits[i]) begin
                m = 16'h0001 << bits[i];
                tgt = (bits[i] == BIT_PEER) ? 1 - s : s;
                fire(s, m, 4'h0);
                apb(1'b0, (tgt == 1) ? OFS_FLAGS_B : OFS_FLAGS_A, 32'h0);
                chk(d, {16'h0, m});
                chk({31'h0, (tgt == 1) ? irq_b : irq_a}, 32'h1);
                apb(1'b1, (tgt == 1) ? OFS_FLAGS_B : OFS_FLAGS_A, {16'h0, m});
                apb(1'b0, (tgt == 1) ? OFS_FLAGS_B : OFS_FLAGS_A, 32'h0);
                chk(d, 32'h0);
            end
        end
        $display("test mapping done");
        // Mask gates the core request
        apb(1'b1, OFS_MASK_A, 32'h0);
        fire(0, 16'h0008, 4'h0);
        chk({31'h0, irq_a}, 32'h0);
        apb(1'b1, OFS_MASK_A, 32'h8);
        repeat (2) @(posedge clk_sys_i);
        chk({31'h0, irq_a}, 32'h1);
        apb(1'b1, OFS_FLAGS_A, 32'h8);
        repeat (2) @(posedge clk_sys_i);
        chk({31'h0, irq_a}, 32'h0);
        // DMA selected: serial events on shared bits are ignored
        apb(1'b1, OFS_SRC_SEL, 32'h0F);
        fire(0, 16'h0CC0, 4'h0);
        apb(1'b0, OFS_FLAGS_A, 32'h0);
        chk(d, 32'h0);
        fire(0, 16'h0CC0, 4'hF);
        apb(1'b0, OFS_FLAGS_A, 32'h0);
        chk(d, 32'h0CC0);
        // Core B routing nibble selects its DMA channels
        apb(1'b1, OFS_SRC_SEL, 32'hF0);
        fire(1, 16'h0CC0, 4'hF);
        apb(1'b0, OFS_FLAGS_B, 32'h0);
        chk(d, 32'h0CC0);
        $display("test gating done");
        // Deep sleep, each core arriving first in turn
        apb(1'b1, OFS_EVT_MASK, 32'h3);
        for (int o = 0; o < 2; o++) begin
            @(posedge clk_sys_i);
            if (o == 0) sleep_a <= 1'b1;
            else sleep_b <= 1'b1;
            repeat (4) @(posedge clk_sys_i);
            chk({30'h0, asleep, run_en}, 32'h1);
            @(posedge clk_sys_i);
            sleep_a <= 1'b1;
            sleep_b <= 1'b1;
            repeat (3) @(posedge clk_sys_i);
            chk({29'h0, blk_irq, asleep, run_en}, 32'h6);
            apb(1'b0, OFS_SLEEP, 32'h0);
            chk(d, 32'h7);
            apb(1'b0, OFS_EVT_STAT, 32'h0);
            chk(d, 32'h1);
            apb(1'b1, OFS_EVT_STAT, 32'h1);
            repeat (2) @(posedge clk_sys_i);
            chk({31'h0, blk_irq}, 32'h0);
            @(posedge clk_sys_i);
            sleep_a <= 1'b0;
            sleep_b <= 1'b0;
            repeat (3) @(posedge clk_sys_i);
            chk({30'h0, asleep, run_en}, 32'h1);
            apb(1'b0, OFS_EVT_STAT, 32'h0);
            chk(d, 32'h2);
            apb(1'b1, OFS_EVT_STAT, 32'h2);
        end
        $display("test sleep done");
        // Unmapped and unaligned addresses are refused
        apb(1'b0, 8'h20, 32'h0);
        chk({d[30:0], last_err}, 32'h1);
        apb(1'b1, 8'h05, 32'hFFFF);
        chk({31'h0, last_err}, 32'h1);
        apb(1'b0, OFS_MASK_A, 32'h0);
        chk(d, 32'h8);
        $display("test refusal done");
        complete_run();
    end
endmodule
